/* File: tsr_pkg.sv */
// Purpose: Shared constants and types for the serial temperature link.
// Assumes: System clock of 200 MHz on both ends.
// Notes: Times are kept in their own unit; cycle counts derive from them.
package tsr_pkg;
  localparam int SYS_CLK_NS = 5;
  localparam int SYS_CLK_MHZ = 200;
  localparam int CONV_TIME_MS = 43;
  localparam int CONV_CYCLES = CONV_TIME_MS * 1000 * SYS_CLK_MHZ;
  localparam int CLOCK_PERIOD_MIN_NS = 765;
  localparam int SC_HALF_CYC =
    (CLOCK_PERIOD_MIN_NS + 2 * SYS_CLK_NS - 1) / (2 * SYS_CLK_NS);
  localparam int BUS_IDLE_GAP_NS = 5000;
  localparam int GAP_CYC = (BUS_IDLE_GAP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int CS_SETUP_NS = 1250;
  localparam int CS_SETUP_CYC = (CS_SETUP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int TMR_W = 24;
  localparam int WORD_W = 16;
  localparam logic [3:0] LAST_WORD_BIT = 4'hF;
  localparam logic [3:0] LAST_BYTE_BIT = 4'h7;
  localparam logic [5:0] TEMP_END = 6'h10;
  localparam logic [5:0] CMD_END = 6'h18;
  localparam logic [5:0] LAST_SHORT = 6'h0F;
  localparam logic [5:0] LAST_LONG = 6'h27;
  localparam int CMD_RD_POS = 7;
  localparam logic [6:0] ADDR_TEMP = 7'h00;
  localparam logic [6:0] ADDR_CTRL = 7'h01;
  localparam logic [6:0] ADDR_ID = 7'h07;
  localparam int CTRL_SD_POS = 15;
  localparam int BYTE_SD_POS = CTRL_SD_POS - 8;
  localparam logic [15:0] CTRL_SD_MASK = 16'h8000;
  localparam logic [15:0] TEMP_POR = 16'h0000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  typedef enum logic [1:0] {PH_TEMP, PH_CMD, PH_DATA} tsr_phase_t;
  typedef enum logic [1:0] {CV_RUN, CV_WAIT, CV_SD} tsr_cv_st_t;
  typedef enum logic [2:0] {
    IN_SD_ON, IN_HOLD_ON, IN_SD_OFF, IN_HOLD_OFF, IN_DONE
  } tsr_init_t;
  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_LOW, H_HIGH, H_TAIL, H_GAP, H_HOLD
  } tsr_hst_t;
endpackage

/* File: tsr_link_if.sv */
// Purpose: Three-wire link between the master and the sensor.
// Assumes: Only the master drives chip select and the serial clock.
// Notes: The data wire idles high, as with a pull-up, when nobody drives.
`timescale 1ns/1ps
interface tsr_link_if;
  logic cs_n;
  logic serial_clock_pin;
  logic host_sio_o;
  logic host_sio_oe;
  logic dev_sio_o;
  logic dev_sio_oe;
  logic sio;

  assign sio = host_sio_oe ? host_sio_o : (dev_sio_oe ? dev_sio_o : 1'b1);

  modport host (
    output cs_n,
    output serial_clock_pin,
    output host_sio_o,
    output host_sio_oe,
    input sio
  );
  modport dev (
    input cs_n,
    input serial_clock_pin,
    input sio,
    output dev_sio_o,
    output dev_sio_oe
  );
endinterface

/* File: tsr_sync.sv */
// Purpose: Two-flop synchroniser for levels entering a clock domain.
// Assumes: The input is a level that stays for several clock cycles.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/1ps
module tsr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tsr_sync_t;
  tsr_sync_t s_q;
  tsr_sync_t s_d;

  always_comb begin
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= {RST_VAL, RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.s2;
endmodule

/* File: tsr_dev.sv */
// Purpose: Sensor end of the three-wire temperature link.
// Assumes: Link logic runs on the master's serial clock, which stops
//   between frames; conversion timing runs on sys_clk.
// Notes: The analog converter is modelled by sampling temp_in at the end
//   of each conversion period.
`timescale 1ns/1ps
// Notes on behaviour
// - Master runs software reset after power-up.
// - Master holds shutdown set one conversion time.
// - Clearing shutdown resumes continuous conversion.
// - Master waits a conversion time before trusting.
// - Registers hold power-on defaults after reset.
// - Undefined reads give zero, writes ignored.
// - Reads allowed anytime, give latest result.
// - Reads never abort a running conversion.
// - Read end refreshes output, starts conversion.
// - Chip select idles high five microseconds.
// - Serial clock period at least 765 ns.
// - Read-only identity register over the link.
// - Worst conversion time is 43 ms.
// - First sixteen clocks shift temperature out.
// - Then command byte in; whole bytes latched.
// - Master alone drives select and clock.
module tsr_dev #(
  parameter int CONV_CYCLES = tsr_pkg::CONV_CYCLES,
  // Identity value is arbitrary.
  parameter logic [15:0] ID_VALUE = 16'h5A01
) (
  tsr_link_if.dev link,
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [tsr_pkg::WORD_W-1:0] temp_in,
  output logic shutdown,
  output logic conv_busy
);
  localparam int CW = $clog2(CONV_CYCLES);

  if (CONV_CYCLES < 2) begin : g_chk
    $error("CONV_CYCLES must be at least 2");
  end

  typedef struct packed {
    tsr_pkg::tsr_phase_t ph;
    logic [3:0] bit_n;
    logic [15:0] sh;
    logic [7:0] cmd;
  } tsr_lk_t;

  typedef struct packed {
    tsr_pkg::tsr_cv_st_t st;
    logic cs_d;
    logic [CW-1:0] cnt;
    logic [15:0] res;
    logic [15:0] snap;
  } tsr_cv_t;

  tsr_lk_t lk_q;
  tsr_lk_t lk_d;
  tsr_cv_t cv_q;
  tsr_cv_t cv_d;
  logic sd_q;
  logic sd_d;
  logic frame_rst_n;
  logic wr_hi;
  logic [7:0] in_byte;
  logic [15:0] rd_word;
  logic cs_s;
  logic sd_s;
  logic read_end;

  // Register read decode; holes read as zero.
  function automatic logic [15:0] reg_read(
    input logic [6:0] addr,
    input logic [15:0] snap,
    input logic sd
  );
    reg_read = tsr_pkg::ZERO_WORD;
    case (addr)
      tsr_pkg::ADDR_TEMP: reg_read = snap;
      tsr_pkg::ADDR_CTRL: reg_read = sd ? tsr_pkg::CTRL_SD_MASK
                                        : tsr_pkg::ZERO_WORD;
      tsr_pkg::ADDR_ID: reg_read = ID_VALUE;
      default: reg_read = tsr_pkg::ZERO_WORD;
    endcase
  endfunction

  // A raised select ends the frame at once, even mid-word, without
  // needing a serial clock edge that may never come.
  assign frame_rst_n = rstn & ~link.cs_n;
  assign in_byte = {lk_q.sh[6:0], link.sio};
  assign rd_word = reg_read(lk_q.cmd[6:0], cv_q.snap, sd_q);

  always_comb begin
    lk_d = lk_q;
    wr_hi = 1'b0;
    sd_d = sd_q;
    lk_d.bit_n = lk_q.bit_n + 4'h1;
    case (lk_q.ph)
      tsr_pkg::PH_TEMP: begin
        if (lk_q.bit_n == tsr_pkg::LAST_WORD_BIT) begin
          lk_d.ph = tsr_pkg::PH_CMD;
        end
      end
      tsr_pkg::PH_CMD: begin
        lk_d.sh = {lk_q.sh[14:0], link.sio};
        if (lk_q.bit_n == tsr_pkg::LAST_BYTE_BIT) begin
          lk_d.cmd = in_byte;
          lk_d.ph = tsr_pkg::PH_DATA;
          lk_d.bit_n = 4'h0;
        end
      end
      tsr_pkg::PH_DATA: begin
        lk_d.sh = {lk_q.sh[14:0], link.sio};
        if (!lk_q.cmd[tsr_pkg::CMD_RD_POS] &&
            lk_q.bit_n == tsr_pkg::LAST_BYTE_BIT) begin
          wr_hi = lk_q.cmd[6:0] == tsr_pkg::ADDR_CTRL;
        end
        if (lk_q.bit_n == tsr_pkg::LAST_WORD_BIT) begin
          lk_d.ph = tsr_pkg::PH_CMD;
        end
      end
      default: lk_d.ph = tsr_pkg::PH_TEMP;
    endcase
    // The low control byte holds only reserved bits, so it stores nothing.
    if (wr_hi) begin
      sd_d = in_byte[tsr_pkg::BYTE_SD_POS];
    end
  end

  always_ff @(posedge link.serial_clock_pin or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      lk_q <= '{ph: tsr_pkg::PH_TEMP, bit_n: 4'h0, sh: 16'h0000,
                cmd: 8'h00};
    end else begin
      lk_q <= lk_d;
    end
  end

  always_ff @(posedge link.serial_clock_pin or negedge rstn) begin
    if (!rstn) begin
      sd_q <= 1'b0;
    end else begin
      sd_q <= sd_d;
    end
  end

  // The sensor only ever drives the data wire, never select or clock.
  always_comb begin
    link.dev_sio_oe = 1'b0;
    link.dev_sio_o = 1'b0;
    if (!link.cs_n) begin
      case (lk_q.ph)
        tsr_pkg::PH_TEMP: begin
          link.dev_sio_oe = 1'b1;
          link.dev_sio_o = cv_q.snap[~lk_q.bit_n];
        end
        tsr_pkg::PH_DATA: begin
          // The first read bit waits for the clock to fall, when the master
          // has let go of its last command bit; this is the turn-around.
          link.dev_sio_oe = lk_q.cmd[tsr_pkg::CMD_RD_POS] &&
                            !(lk_q.bit_n == 4'h0 && link.serial_clock_pin);
          link.dev_sio_o = rd_word[~lk_q.bit_n];
        end
        default: begin
          link.dev_sio_oe = 1'b0;
          link.dev_sio_o = 1'b0;
        end
      endcase
    end
  end

  tsr_sync #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
    .clk(sys_clk),
    .rstn(rstn),
    .d(link.cs_n),
    .q(cs_s)
  );

  tsr_sync #(.W(1), .RST_VAL(1'b0)) u_sd_sync (
    .clk(sys_clk),
    .rstn(rstn),
    .d(sd_q),
    .q(sd_s)
  );

  // The snapshot changes only while select is seen high, so the link
  // domain reads a still word during a frame. Select setup time before
  // the first clock edge covers the few cycles of synchroniser lag.
  assign read_end = cs_s & ~cv_q.cs_d;

  always_comb begin
    cv_d = cv_q;
    cv_d.cs_d = cs_s;
    if (read_end) begin
      cv_d.snap = cv_q.res;
    end
    case (cv_q.st)
      tsr_pkg::CV_RUN: begin
        // A frame never cuts a count short; a frame still running at its end holds the next count in CV_WAIT until the read ends.
        if (sd_s) begin
          cv_d.st = tsr_pkg::CV_SD;
          cv_d.cnt = '0;
        end else if (cv_q.cnt == CW'(CONV_CYCLES - 1)) begin
          cv_d.res = temp_in;
          cv_d.cnt = '0;
          if (cs_s) begin
            cv_d.snap = temp_in;
          end else begin
            cv_d.st = tsr_pkg::CV_WAIT;
          end
        end else begin
          cv_d.cnt = cv_q.cnt + CW'(1);
        end
      end
      tsr_pkg::CV_WAIT: begin
        if (sd_s) begin
          cv_d.st = tsr_pkg::CV_SD;
        end else if (read_end) begin
          cv_d.st = tsr_pkg::CV_RUN;
        end
      end
      tsr_pkg::CV_SD: begin
        if (!sd_s) begin
          cv_d.st = tsr_pkg::CV_RUN;
          cv_d.cnt = '0;
        end
      end
      default: cv_d.st = tsr_pkg::CV_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cv_q <= '{st: tsr_pkg::CV_RUN, cs_d: 1'b1, cnt: '0,
                res: tsr_pkg::TEMP_POR, snap: tsr_pkg::TEMP_POR};
    end else begin
      cv_q <= cv_d;
    end
  end

  assign shutdown = sd_q;
  assign conv_busy = cv_q.st == tsr_pkg::CV_RUN;
endmodule

/* File: tsr_host.sv */
// Purpose: Master end of the link; makes select, serial clock and frames.
// Assumes: sys_clk is free running; the serial clock is divided from it.
// Notes: After reset the master runs the shutdown reset sequence before
//   it accepts any user request.
`timescale 1ns/1ps
module tsr_host #(
  parameter int CONV_CYCLES = tsr_pkg::CONV_CYCLES
) (
  tsr_link_if.host link,
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_xfer,
  input wire logic [7:0] req_cmd,
  input wire logic [15:0] req_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_temp,
  output logic [15:0] rsp_rdata,
  output logic init_done
);
  localparam int TW = tsr_pkg::TMR_W;
  localparam logic [TW-1:0] HALF = TW'(tsr_pkg::SC_HALF_CYC - 1);

  if (CONV_CYCLES < 2 || CONV_CYCLES >= 2 ** TW) begin : g_chk
    $error("CONV_CYCLES out of timer range");
  end

  typedef struct packed {
    tsr_pkg::tsr_hst_t st;
    tsr_pkg::tsr_init_t step;
    logic [TW-1:0] tmr;
    logic [5:0] bit_n;
    logic xfer;
    logic rd;
    logic [23:0] out_sh;
    logic [31:0] in_sh;
    logic cs_n;
    logic sc;
    logic oe;
    logic so;
    logic rsp_v;
    logic [15:0] temp;
    logic [15:0] rdata;
  } tsr_h_t;

  tsr_h_t h_q;
  tsr_h_t h_d;
  logic sio_s;
  logic last;

  function automatic logic host_drv(
    input logic [5:0] b,
    input logic rd
  );
    host_drv = (b >= tsr_pkg::TEMP_END && b < tsr_pkg::CMD_END) ||
               (b >= tsr_pkg::CMD_END && !rd);
  endfunction

  function automatic tsr_h_t start_fr(
    input tsr_h_t h,
    input logic x,
    input logic [7:0] c,
    input logic [15:0] w
  );
    start_fr = h;
    start_fr.st = tsr_pkg::H_SETUP;
    start_fr.tmr = TW'(tsr_pkg::CS_SETUP_CYC - 1);
    start_fr.cs_n = 1'b0;
    start_fr.bit_n = 6'h00;
    start_fr.xfer = x;
    start_fr.rd = c[tsr_pkg::CMD_RD_POS];
    start_fr.out_sh = {c, w};
  endfunction

  tsr_sync #(.W(1), .RST_VAL(1'b1)) u_sio_sync (
    .clk(sys_clk),
    .rstn(rstn),
    .d(link.sio),
    .q(sio_s)
  );

  assign last = h_q.bit_n == (h_q.xfer ? tsr_pkg::LAST_LONG
                                       : tsr_pkg::LAST_SHORT);

  always_comb begin
    h_d = h_q;
    h_d.rsp_v = 1'b0;
    if (h_q.tmr != '0) begin
      h_d.tmr = h_q.tmr - TW'(1);
    end
    case (h_q.st)
      tsr_pkg::H_IDLE: begin
        if (h_q.step == tsr_pkg::IN_SD_ON) begin
          h_d = start_fr(h_q, 1'b1, {1'b0, tsr_pkg::ADDR_CTRL},
                         tsr_pkg::CTRL_SD_MASK);
        end else if (h_q.step == tsr_pkg::IN_SD_OFF) begin
          h_d = start_fr(h_q, 1'b1, {1'b0, tsr_pkg::ADDR_CTRL},
                         tsr_pkg::ZERO_WORD);
        end else if (h_q.step == tsr_pkg::IN_DONE && req_valid) begin
          h_d = start_fr(h_q, req_xfer, req_cmd, req_wdata);
        end
      end
      tsr_pkg::H_SETUP: begin
        if (h_q.tmr == '0) begin
          h_d.st = tsr_pkg::H_LOW;
          h_d.tmr = HALF;
        end
      end
      tsr_pkg::H_LOW: begin
        if (h_q.tmr == '0) begin
          h_d.st = tsr_pkg::H_HIGH;
          h_d.sc = 1'b1;
          h_d.tmr = HALF;
          if (!host_drv(h_q.bit_n, h_q.rd)) begin
            h_d.in_sh = {h_q.in_sh[30:0], sio_s};
          end
        end
      end
      tsr_pkg::H_HIGH: begin
        if (h_q.tmr == '0) begin
          h_d.sc = 1'b0;
          h_d.tmr = HALF;
          if (last) begin
            h_d.st = tsr_pkg::H_TAIL;
            h_d.oe = 1'b0;
          end else begin
            h_d.st = tsr_pkg::H_LOW;
            h_d.bit_n = h_q.bit_n + 6'h01;
            h_d.oe = host_drv(h_d.bit_n, h_q.rd);
            if (h_d.oe) begin
              h_d.so = h_q.out_sh[23];
              h_d.out_sh = {h_q.out_sh[22:0], 1'b0};
            end
          end
        end
      end
      tsr_pkg::H_TAIL: begin
        if (h_q.tmr == '0) begin
          h_d.cs_n = 1'b1;
          h_d.st = tsr_pkg::H_GAP;
          h_d.tmr = TW'(tsr_pkg::GAP_CYC - 1);
          h_d.temp = (h_q.xfer && h_q.rd) ? h_q.in_sh[31:16]
                                          : h_q.in_sh[15:0];
          h_d.rdata = h_q.in_sh[15:0];
          case (h_q.step)
            tsr_pkg::IN_SD_ON: h_d.step = tsr_pkg::IN_HOLD_ON;
            tsr_pkg::IN_SD_OFF: h_d.step = tsr_pkg::IN_HOLD_OFF;
            default: h_d.rsp_v = 1'b1;
          endcase
        end
      end
      tsr_pkg::H_GAP: begin
        if (h_q.tmr == '0) begin
          h_d.st = tsr_pkg::H_IDLE;
          if (h_q.step == tsr_pkg::IN_HOLD_ON ||
              h_q.step == tsr_pkg::IN_HOLD_OFF) begin
            h_d.st = tsr_pkg::H_HOLD;
            h_d.tmr = TW'(CONV_CYCLES - 1);
          end
        end
      end
      tsr_pkg::H_HOLD: begin
        if (h_q.tmr == '0) begin
          h_d.st = tsr_pkg::H_IDLE;
          h_d.step = (h_q.step == tsr_pkg::IN_HOLD_ON) ?
                     tsr_pkg::IN_SD_OFF : tsr_pkg::IN_DONE;
        end
      end
      default: h_d.st = tsr_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      h_q <= '{st: tsr_pkg::H_IDLE, step: tsr_pkg::IN_SD_ON, tmr: '0,
               bit_n: 6'h00, xfer: 1'b0, rd: 1'b0, out_sh: 24'h000000,
               in_sh: 32'h00000000, cs_n: 1'b1, sc: 1'b0, oe: 1'b0,
               so: 1'b0, rsp_v: 1'b0, temp: 16'h0000, rdata: 16'h0000};
    end else begin
      h_q <= h_d;
    end
  end

  assign link.cs_n = h_q.cs_n;
  assign link.serial_clock_pin = h_q.sc;
  assign link.host_sio_o = h_q.so;
  assign link.host_sio_oe = h_q.oe;
  assign req_ready = h_q.st == tsr_pkg::H_IDLE &&
                     h_q.step == tsr_pkg::IN_DONE;
  assign rsp_valid = h_q.rsp_v;
  assign rsp_temp = h_q.temp;
  assign rsp_rdata = h_q.rdata;
  assign init_done = h_q.step == tsr_pkg::IN_DONE;
endmodule

/* File: tsr_link_properties.sv */
// Purpose: Protocol checks on the three-wire temperature link.
// Assumes: The serial clock and select are sampled as levels on sys_clk.
// Notes: The gap, low and period counters saturate so long idle spells never wrap.
`timescale 1ns/1ps
module tsr_link_properties (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic serial_clock_pin,
  input wire logic host_sio_o,
  input wire logic host_sio_oe,
  input wire logic dev_sio_o,
  input wire logic dev_sio_oe,
  input wire logic sio
);
  localparam int PER_MIN = tsr_pkg::CLOCK_PERIOD_MIN_NS / tsr_pkg::SYS_CLK_NS;
  logic [15:0] gap_q;
  logic [15:0] low_q;
  logic [15:0] per_q;
  logic [5:0] edge_q;
  logic sck_q;
  logic rise;

  assign rise = serial_clock_pin & ~sck_q;

  // Gap and period start saturated, so the first frame after reset is
  // not taken for one that followed a short gap.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gap_q <= 16'hFFFF;
      low_q <= 16'h0000;
      per_q <= 16'hFFFF;
      edge_q <= 6'h00;
      sck_q <= 1'b0;
    end else begin
      sck_q <= serial_clock_pin;
      gap_q <= cs_n ? gap_q + {15'h0000, gap_q != 16'hFFFF} : 16'h0000;
      low_q <= cs_n ? 16'h0000 : low_q + {15'h0000, low_q != 16'hFFFF};
      per_q <= rise ? 16'h0001 : per_q + {15'h0000, per_q != 16'hFFFF};
      edge_q <= cs_n ? 6'h00 : edge_q + {5'h00, rise};
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  idle_clk_low_a: assert property (cs_n |-> !serial_clock_pin)
    else $error("serial clock high while deselected");
  no_contention_a: assert property (!(host_sio_oe && dev_sio_oe))
    else $error("both ends drive the data wire");
  bus_gap_a: assert property (
    $fell(cs_n) |-> gap_q >= 16'(tsr_pkg::GAP_CYC))
    else $error("select idle gap too short");
  select_setup_a: assert property (
    $rose(serial_clock_pin) |-> low_q >= 16'(tsr_pkg::CS_SETUP_CYC))
    else $error("clock rose too soon after select");
  clk_period_a: assert property (
    $rose(serial_clock_pin) |-> per_q >= 16'(PER_MIN))
    else $error("serial clock period too short");
  frame_len_a: assert property (
    $rose(cs_n) |-> edge_q == 6'h10 || edge_q == 6'h28)
    else $error("frame not made of whole units");
  temp_drive_a: assert property (
    !cs_n && $past(!cs_n) && edge_q < 6'h0F |-> dev_sio_oe)
    else $error("sensor not driving during temperature bits");
  dev_quiet_a: assert property (
    dev_sio_oe |-> !cs_n && (edge_q < 6'h10 ||
                             (edge_q >= 6'h18 && edge_q < 6'h28)))
    else $error("sensor drives outside its output slots");
  host_hold_a: assert property (
    host_sio_oe && serial_clock_pin |-> $stable(host_sio_o))
    else $error("master data moved while clock high");
  bus_release_a: assert property (
    cs_n && $past(cs_n) |-> !host_sio_oe && !dev_sio_oe)
    else $error("data wire driven between frames");
  sio_pullup_a: assert property (
    !host_sio_oe && !dev_sio_oe |-> sio)
    else $error("released data wire not pulled high");

  cover property ($rose(cs_n) && edge_q == 6'h10);
  cover property ($rose(cs_n) && edge_q == 6'h28);
  cover property ($fell(dev_sio_oe) && !cs_n);
endmodule

/* File: temp_sensor_serial_reset_control_tb.sv */
// Purpose: Drives the master end and judges both ends of the link.
// Assumes: A short conversion count keeps the run brief.
// Notes: Each scenario checks its own results before returning.
`timescale 1ns/1ps
module temp_sensor_serial_reset_control_tb;
  localparam int CONV = 200;
  // Identity value is arbitrary.
  localparam logic [15:0] ID_VAL = 16'h3C5A;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid, req_ready, req_xfer, rsp_valid, init_done;
  logic shutdown, conv_busy;
  logic [7:0] req_cmd;
  logic [15:0] req_wdata, rsp_temp, rsp_rdata, temp_in;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;

  tsr_link_if tsr_link_if_inst ();
  tsr_host #(.CONV_CYCLES(CONV)) tsr_host_inst (
    .link(tsr_link_if_inst.host), .sys_clk(sys_clk), .rstn(rstn),
    .req_valid(req_valid), .req_ready(req_ready), .req_xfer(req_xfer),
    .req_cmd(req_cmd), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_temp(rsp_temp), .rsp_rdata(rsp_rdata), .init_done(init_done));
  tsr_dev #(.CONV_CYCLES(CONV), .ID_VALUE(ID_VAL)) tsr_dev_inst (
    .link(tsr_link_if_inst.dev), .sys_clk(sys_clk), .rstn(rstn),
    .temp_in(temp_in), .shutdown(shutdown), .conv_busy(conv_busy));
  tsr_link_properties tsr_link_properties_inst (
    .sys_clk(sys_clk), .rstn(rstn), .cs_n(tsr_link_if_inst.cs_n),
    .serial_clock_pin(tsr_link_if_inst.serial_clock_pin),
    .host_sio_o(tsr_link_if_inst.host_sio_o),
    .host_sio_oe(tsr_link_if_inst.host_sio_oe),
    .dev_sio_o(tsr_link_if_inst.dev_sio_o),
    .dev_sio_oe(tsr_link_if_inst.dev_sio_oe), .sio(tsr_link_if_inst.sio));

  always #2.5 sys_clk = ~sys_clk;

  task finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Init plus all scenario frames need about 89400 cycles.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 98000) begin
      $display("BAD run_length exp below 98000 got %0d", cyc);
      error_cnt++;
      finish_test();
    end
  end

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", what, exp, got);
      error_cnt++;
    end
  endtask

  // Request is held until the edge at which it is taken.
  task xfer(input logic x, input logic [7:0] c, input logic [15:0] w);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 8000);
    req_valid <= 1'b1;
    req_xfer <= x;
    req_cmd <= c;
    req_wdata <= w;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 8000);
    chk("frame_done", 16'h0001, {15'h0000, rsp_valid});
  endtask

  task t_init();
    int n;
    n = 0;
    while (shutdown !== 1'b1 && n < 10000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("sd_set_at_init", 16'h0001, {15'h0000, shutdown});
    n = 0;
    while (shutdown === 1'b1 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("sd_hold_long", 16'h0001, {15'h0000, n >= CONV});
    n = 0;
    while (init_done !== 1'b1 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("wait_after_clear", 16'h0001, {15'h0000, n >= CONV});
    xfer(1'b1, 8'h81, 16'h0000);
    chk("ctrl_default", 16'h0000, rsp_rdata);
    chk("temp_after_init", 16'h4B01, rsp_temp);
  endtask

  task t_id_hole();
    xfer(1'b1, 8'h07, 16'h1234);
    xfer(1'b1, 8'h05, 16'hFFFF);
    chk("sd_after_hole_write", 16'h0000, {15'h0000, shutdown});
    xfer(1'b1, 8'h87, 16'h0000);
    chk("id_read", ID_VAL, rsp_rdata);
    xfer(1'b1, 8'h85, 16'h0000);
    chk("hole_read", 16'h0000, rsp_rdata);
  endtask

  task t_shutdown();
    xfer(1'b1, 8'h01, 16'h8000);
    temp_in <= 16'h2800;
    repeat (2 * CONV) @(posedge sys_clk);
    chk("sd_on", 16'h0001, {15'h0000, shutdown});
    chk("busy_in_sd", 16'h0000, {15'h0000, conv_busy});
    xfer(1'b1, 8'h81, 16'h0000);
    chk("ctrl_sd", 16'h8000, rsp_rdata);
    chk("temp_frozen", 16'h4B01, rsp_temp);
    xfer(1'b1, 8'h01, 16'h0000);
    chk("sd_off", 16'h0000, {15'h0000, shutdown});
    repeat (CONV + 50) @(posedge sys_clk);
    chk("busy_after_sd", 16'h0001, {15'h0000, conv_busy});
    xfer(1'b0, 8'h00, 16'h0000);
    chk("temp_resumed", 16'h2800, rsp_temp);
  endtask

  // The sample changes while a frame is running.
  task t_mid_read();
    fork
      xfer(1'b0, 8'h00, 16'h0000);
      begin
        @(negedge tsr_link_if_inst.cs_n);
        repeat (500) @(posedge sys_clk);
        temp_in <= 16'hEC00;
      end
    join
    chk("temp_in_frame", 16'h2800, rsp_temp);
    repeat (2 * CONV + 50) @(posedge sys_clk);
    xfer(1'b1, 8'h80, 16'h0000);
    chk("temp_after_read", 16'hEC00, rsp_temp);
    chk("temp_reg_read", 16'hEC00, rsp_rdata);
  endtask

  initial begin
    temp_in = 16'h4B01;
    req_valid = 1'b0;
    req_xfer = 1'b0;
    req_cmd = 8'h00;
    req_wdata = 16'h0000;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    t_init();
    t_id_hole();
    t_shutdown();
    t_mid_read();
    finish_test();
  end
endmodule
